/* File: shared/pcfg_consts.vh */
// Register offsets, field layout, reset values and mode codes for the port.
`ifndef PCFG_CONSTS_VH
`define PCFG_CONSTS_VH
`define PCFG_ADDR_W            8
`define PCFG_BANK0             1'b0
`define PCFG_BANK1             1'b1
`define PCFG_OFF_P0_PULLUP     8'hE7
`define PCFG_OFF_P1_MODE_HIGH  8'hE4
`define PCFG_OFF_P1_MODE_LOW   8'hEB
`define PCFG_OFF_P1_DATA       8'hF1
`define PCFG_OFF_P1_OUT_PULLUP 8'hF2
`define PCFG_RST_P0_PULLUP     8'h00
`define PCFG_RST_P1_MODE       8'h00
`define PCFG_RST_P1_DATA       8'h00
`define PCFG_RST_P1_OUT_PULLUP 8'h00
`define PCFG_MODE_W            2
`define PCFG_MODE_IN           2'b00
`define PCFG_MODE_OPEN_DRAIN   2'b01
`define PCFG_MODE_PUSH_PULL    2'b10
`define PCFG_MODE_IN_PULLUP    2'b11
`endif

/* File: core/pcfg_pin.v */
// One Port 1 pin: mode decode into drive, enable and pull-up controls.
`timescale 1ns/1ns
`default_nettype none
`include "pcfg_consts.vh"
module pcfg_pin (
  input  wire [1:0] i_mode,
  input  wire       i_out_value,
  input  wire       i_out_pullup,
  input  wire       i_pin_level,
  output reg        o_pin_out,
  output reg        o_pin_oe,
  output reg        o_pullup,
  output reg        o_read_value
);
  // ----------------------------------------------------------------
  // Mode decode.
  // ----------------------------------------------------------------
  always @* begin
    o_pin_out    = 1'b0;
    o_pin_oe     = 1'b0;
    o_pullup     = 1'b0;
    o_read_value = i_pin_level;
    case (i_mode)
      `PCFG_MODE_OPEN_DRAIN: begin
        o_pin_out    = 1'b0;
        o_pin_oe     = ~i_out_value;
        o_pullup     = i_out_pullup;
        o_read_value = i_out_value;
      end
      `PCFG_MODE_PUSH_PULL: begin
        o_pin_out    = i_out_value;
        o_pin_oe     = 1'b1;
        o_pullup     = i_out_pullup;
        o_read_value = i_out_value;
      end
      `PCFG_MODE_IN_PULLUP: begin
        o_pullup = 1'b1;
      end
      default: begin
        o_pullup = 1'b0;
      end
    endcase
  end
endmodule // pcfg_pin
`default_nettype wire

/* File: core/pcfg_port.v */
// Port 1 configuration, data and pull-up registers with Port 0 pull-ups.
//
// Contract
// - One Port 0 pull-up bit per pin; 1 connects, 0 disconnects.
// - Port 0 pull-up register at set 1 bank 0 E7h, cleared by reset.
// - Port 1 data register at set 1 bank 1 F1h drives pins, reads state; reads in output modes return the register, not the pin.
// - Each Port 1 pin is input, input with pull-up, open-drain or push-pull.
// - High mode register covers pins 7..4, low covers 3..0, two bits each.
// - Reset clears both mode registers, so all pins start as inputs.
// - Mode 00 input, 01 open-drain, 10 push-pull, 11 input variant.
// - Input-mode pull-up of Port 1 comes from the mode field.
// - Output-mode pull-up enable per pin at set 1 bank 1 F2h, reset 0.
`timescale 1ns/1ns
`default_nettype none
`include "pcfg_consts.vh"
module pcfg_port #(
  parameter WIDTH = 8
) (
  input  wire             i_clk,
  input  wire             i_rst,
  input  wire             i_bank,
  input  wire [7:0]       i_addr,
  input  wire             i_wr,
  input  wire             i_rd,
  input  wire [7:0]       i_wdata,
  output reg  [7:0]       o_rdata,
  output reg              o_rhit,
  input  wire [WIDTH-1:0] i_p1_pin,
  output wire [WIDTH-1:0] o_p1_out,
  output wire [WIDTH-1:0] o_p1_oe,
  output wire [WIDTH-1:0] o_p1_pullup,
  output wire [WIDTH-1:0] o_p0_pullup
);
  // ----------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------
  reg  [7:0]       port_zero_pullup_enable;
  reg  [7:0]       port_one_mode_high;
  reg  [7:0]       port_one_mode_low;
  reg  [7:0]       port_one_pin_data;
  reg  [7:0]       port_one_output_pullup_enable;
  reg  [WIDTH-1:0] pin_meta;
  reg  [WIDTH-1:0] pin_sync;
  wire [15:0]      mode_all;
  wire [WIDTH-1:0] read_bits;
  wire             sel_p0_pu;
  wire             sel_mode_h;
  wire             sel_mode_l;
  wire             sel_data;
  wire             sel_out_pu;
  wire             wr_p0_pu;
  wire             wr_mode_h;
  wire             wr_mode_l;
  wire             wr_data;
  wire             wr_out_pu;
  reg  [7:0]       next_rdata;
  reg              next_rhit;

  // ----------------------------------------------------------------
  // Address decode.
  // ----------------------------------------------------------------
  assign sel_p0_pu  = (i_bank == `PCFG_BANK0) &&
                      (i_addr == `PCFG_OFF_P0_PULLUP);
  assign sel_mode_h = (i_bank == `PCFG_BANK0) &&
                      (i_addr == `PCFG_OFF_P1_MODE_HIGH);
  assign sel_mode_l = (i_bank == `PCFG_BANK0) &&
                      (i_addr == `PCFG_OFF_P1_MODE_LOW);
  assign sel_data   = (i_bank == `PCFG_BANK1) &&
                      (i_addr == `PCFG_OFF_P1_DATA);
  assign sel_out_pu = (i_bank == `PCFG_BANK1) &&
                      (i_addr == `PCFG_OFF_P1_OUT_PULLUP);

  // ----------------------------------------------------------------
  // Write strobes.
  // ----------------------------------------------------------------
  assign wr_p0_pu  = i_wr & sel_p0_pu;
  assign wr_mode_h = i_wr & sel_mode_h;
  assign wr_mode_l = i_wr & sel_mode_l;
  assign wr_data   = i_wr & sel_data;
  assign wr_out_pu = i_wr & sel_out_pu;

  // ----------------------------------------------------------------
  // Port 0 pull-up enable register.
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_rst) begin
      port_zero_pullup_enable <= `PCFG_RST_P0_PULLUP;
    end else if (wr_p0_pu) begin
      port_zero_pullup_enable <= i_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Port 1 mode register, pins 7 to 4.
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_rst) begin
      port_one_mode_high <= `PCFG_RST_P1_MODE;
    end else if (wr_mode_h) begin
      port_one_mode_high <= i_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Port 1 mode register, pins 3 to 0.
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_rst) begin
      port_one_mode_low <= `PCFG_RST_P1_MODE;
    end else if (wr_mode_l) begin
      port_one_mode_low <= i_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Port 1 data register.
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_rst) begin
      port_one_pin_data <= `PCFG_RST_P1_DATA;
    end else if (wr_data) begin
      port_one_pin_data <= i_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Port 1 output-mode pull-up enable register.
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_rst) begin
      port_one_output_pullup_enable <= `PCFG_RST_P1_OUT_PULLUP;
    end else if (wr_out_pu) begin
      port_one_output_pullup_enable <= i_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Pin input synchroniser, first stage.
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_rst) begin
      pin_meta <= {WIDTH{1'b0}};
    end else begin
      pin_meta <= i_p1_pin;
    end
  end

  // ----------------------------------------------------------------
  // Pin input synchroniser, second stage.
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_rst) begin
      pin_sync <= {WIDTH{1'b0}};
    end else begin
      pin_sync <= pin_meta;
    end
  end

  // ----------------------------------------------------------------
  // Per-pin logic.
  // ----------------------------------------------------------------
  assign mode_all    = {port_one_mode_high, port_one_mode_low};
  assign o_p0_pullup = port_zero_pullup_enable[WIDTH-1:0];

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_pin
      pcfg_pin u_pin (
        .i_mode       (mode_all[2*g+1:2*g]),
        .i_out_value  (port_one_pin_data[g]),
        .i_out_pullup (port_one_output_pullup_enable[g]),
        .i_pin_level  (pin_sync[g]),
        .o_pin_out    (o_p1_out[g]),
        .o_pin_oe     (o_p1_oe[g]),
        .o_pullup     (o_p1_pullup[g]),
        .o_read_value (read_bits[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read path.
  // ----------------------------------------------------------------
  always @* begin
    next_rdata = 8'h00;
    next_rhit  = 1'b1;
    if (sel_p0_pu) begin
      next_rdata = port_zero_pullup_enable;
    end else if (sel_mode_h) begin
      next_rdata = port_one_mode_high;
    end else if (sel_mode_l) begin
      next_rdata = port_one_mode_low;
    end else if (sel_data) begin
      next_rdata = read_bits;
    end else if (sel_out_pu) begin
      next_rdata = port_one_output_pullup_enable;
    end else begin
      next_rhit = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read data register.
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Read hit pulse.
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_rhit <= 1'b0;
    end else begin
      o_rhit <= i_rd & next_rhit;
    end
  end
endmodule // pcfg_port
`default_nettype wire

/* File: verification/pcfg_port_assertions.sv */
// Assertion checker for the port configuration block.
`timescale 1ns/1ns
`default_nettype none
module pcfg_port_assertions #(
  parameter WIDTH = 8
) (
  input wire logic             i_clk,
  input wire logic             i_rst,
  input wire logic             i_bank,
  input wire logic             i_wr,
  input wire logic             i_rd,
  input wire logic             o_rhit,
  input wire logic [7:0]       i_addr,
  input wire logic [7:0]       i_wdata,
  input wire logic [7:0]       o_rdata,
  input wire logic [WIDTH-1:0] i_p1_pin,
  input wire logic [WIDTH-1:0] o_p1_out,
  input wire logic [WIDTH-1:0] o_p1_oe,
  input wire logic [WIDTH-1:0] o_p1_pullup,
  input wire logic [WIDTH-1:0] o_p0_pullup
);
  logic [15:0] md;
  logic [7:0] dat, opu, pp, od, pu;
  wire [8:0] ba = {i_bank, i_addr};
  always_ff @(posedge i_clk) begin
    if (i_rst) {md, dat, opu} <= '0;
    else if (i_wr) begin
      case (ba)
        9'h0e4: md[15:8] <= i_wdata;
        9'h0eb: md[7:0] <= i_wdata;
        9'h1f1: dat <= i_wdata;
        9'h1f2: opu <= i_wdata;
        default: ;
      endcase
    end
  end
  always_comb for (int i = 0; i < 8; i++) begin
    pp[i] = md[2*i+:2] == 2'h2;
    od[i] = md[2*i+:2] == 2'h1;
    pu[i] = md[2*i+:2] == 2'h3;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  reset_idle_a: assert property ($past(i_rst) |-> !o_rhit && !o_p1_oe)
    else $error("not idle after reset");
  pullup_write_a: assert property (i_wr && ba == 9'h0e7
    |=> o_p0_pullup == $past(i_wdata)) else $error("pull-up write lost");
  pullup_read_a: assert property (i_rd && !i_wr && ba == 9'h0e7
    |=> o_rhit && o_rdata == $past(o_p0_pullup)) else $error("bad read");
  data_hit_a: assert property (i_rd && ba == 9'h1f1 |=> o_rhit)
    else $error("data read missed");
  unmapped_a: assert property (i_rd && ba == 9'h0f1
    |=> !o_rhit && o_rdata == 0) else $error("unmapped read hit");
  drive_map_a: assert property (o_p1_out == (dat & pp))
    else $error("drive value wrong");
  enable_map_a: assert property (o_p1_oe == (pp | od & ~dat))
    else $error("enable wrong");
  pullup_map_a: assert property (o_p1_pullup == (pu | (pp | od) & opu))
    else $error("pull-up wrong");
  cover property (o_rhit && o_rdata != 0);
  cover property (|(od & ~dat));
  cover property (|(o_p1_pullup & ~pu));
endmodule // pcfg_port_assertions
`default_nettype wire

/* File: verification/test_pcfg_port.sv */
// Self-checking bench for the port configuration block.
`timescale 1ns/1ns
`default_nettype none
module test_pcfg_port;
  logic i_clk = 0, i_rst = 1, i_bank = 0, i_wr = 0, i_rd = 0, o_rhit, pr = 0;
  logic [7:0] i_addr = 0, i_wdata = 0, i_p1_pin = 0, o_rdata, o_p1_out;
  logic [7:0] o_p1_oe, o_p1_pullup, o_p0_pullup;
  logic [8:0] er = 0;
  int n_mismatch = 0, checks = 0, cyc = 0, mem[int];
  int unsigned x = 31;
  int keys[6] = '{'h0e7, 'h0e4, 'h0eb, 'h1f1, 'h1f2, 'h0f1};
  pcfg_port u_pcfg_port (.i_clk, .i_rst, .i_bank, .i_addr, .i_wr, .i_rd,
    .i_wdata, .o_rdata, .o_rhit, .i_p1_pin, .o_p1_out, .o_p1_oe,
    .o_p1_pullup, .o_p0_pullup);
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 1000) begin
      n_mismatch++;
      stop_test();
    end
  end
  function automatic int unsigned rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [7:0] rg(int k);
    return mem.exists(k) ? 8'(mem[k]) : 8'h00;
  endfunction
  task automatic cmp(logic [31:0] g, logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic acc(bit w, bit r, int k, int d);
    logic [15:0] m;
    logic [7:0] dt, op, om, oe, pu, ou;
    logic [31:0] ex;
    @(negedge i_clk);
    m = {rg('h0e4), rg('h0eb)};
    dt = rg('h1f1);
    op = rg('h1f2);
    for (int i = 0; i < 8; i++) begin
      om[i] = m[2*i+:2] == 2'h1 || m[2*i+:2] == 2'h2;
      oe[i] = m[2*i+:2] == 2'h2 || m[2*i+:2] == 2'h1 && !dt[i];
      pu[i] = m[2*i+:2] == 2'h3 || om[i] && op[i];
      ou[i] = m[2*i+:2] == 2'h2 && dt[i];
    end
    ex = {ou, oe, pu, rg('h0e7)};
    cmp({o_p1_out, o_p1_oe, o_p1_pullup, o_p0_pullup}, ex);
    cmp({o_rhit, pr ? o_rdata : 8'h00}, er);
    pr = r;
    er = r ? {k != 'h0f1, k == 'h1f1 ? dt & om | i_p1_pin & ~om : rg(k)} : 0;
    {i_wr, i_rd, i_bank, i_addr, i_wdata} = {w, r, 9'(k), 8'(d)};
    if (w && k != 'h0f1) mem[k] = d & 'hff;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    for (int p = 0; p < 2; p++) begin
      i_rst = 1;
      mem.delete();
      repeat (8) @(negedge i_clk);
      i_rst = 0;
      foreach (keys[j]) acc(0, 1, keys[j], 0);
      for (int n = 0; n < 40; n++) begin
        i_p1_pin = 8'(rnd());
        acc(1, 0, keys[rnd() % 6], rnd());
        acc(1, 0, keys[rnd() % 6], rnd());
        acc(0, 1, keys[rnd() % 6], 0);
      end
      acc(0, 0, 0, 0);
      $display("Reset and random pass %0d done", p);
    end
    stop_test();
  end
endmodule // test_pcfg_port
bind pcfg_port pcfg_port_assertions #(.WIDTH(WIDTH)) u_chk (.*);
`default_nettype wire
